// >>> common/ifp_pkg.sv
package ifp_pkg;

    localparam int unsigned PC_W        = 21;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned DADDR_W     = 12;
    localparam int unsigned DATA_W      = 8;
    localparam logic [20:0] PC_RESET    = 21'h000000;
    localparam logic [20:0] PC_STEP     = 21'h000002;
    localparam logic [15:0] IR_RESET    = 16'h0000;
    localparam logic [7:0]  DATA_RESET  = 8'h00;
    localparam logic [11:0] DADDR_RESET = 12'h000;

    // phase sequence, gray coded
    typedef enum logic [1:0]
    {
        IFP_PHASE_ONE   = 2'b00,
        IFP_PHASE_TWO   = 2'b01,
        IFP_PHASE_THREE = 2'b11,
        IFP_PHASE_FOUR  = 2'b10
    } ifp_phase_t;

    // decoded execute request from the core decoder
    typedef struct packed
    {
        logic              absolute_jump_instr;
        logic              relative_branch;
        logic              two_word;
        logic [19:0]       jump_word_addr;
        logic signed [10:0] branch_offset;
        logic              operand_read;
        logic              dest_write;
        logic [11:0]       data_addr;
    } ifp_exec_t;

endpackage

// >>> verilog/ifp_core.sv
// What this block does
// RULE1: four phases per instruction cycle, phase_one to phase_four, from mclk.
// RULE2: fetch one cycle, execute next cycle overlapped with following fetch.
// RULE3: pc-changing instructions take two cycles; prefetched word is flushed.
// RULE4: program counter increments in phase_one of every fetch cycle.
// RULE5: fetched word latched into instruction_register in phase_one, executed later.
// RULE6: data operand read in phase_two, destination written in phase_four.
// RULE7: program memory byte addressed; instructions are one or two words.
// RULE8: low byte of each word sits at even address, high byte next.
// RULE9: pc steps by two per word and its lsb always reads zero.
// RULE10: absolute target word address loads pc bits 20 down to 1.
// RULE11: relative branch displacement in bytes is twice the encoded offset.
// RULE12: after reset no valid instruction; first cycle only fetches reset address.
module ifp_core
    import ifp_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    input  wire logic [15:0]          prog_word,
    input  wire ifp_exec_t            exec_req,
    input  wire logic [7:0]           data_rd,
    input  wire logic [7:0]           result,
    output logic [20:0]               prog_addr,
    output logic                      prog_rd_en,
    output logic [15:0]               instruction_register,
    output logic                      instr_valid,
    output logic                      phase_one,
    output logic                      phase_two,
    output logic                      phase_three,
    output logic                      phase_four,
    output logic [11:0]               data_addr,
    output logic                      data_rd_en,
    output logic                      data_wr_en,
    output logic [7:0]                data_wr,
    output logic [7:0]                operand
);

    ////////////////////////////////////////////////////////////////////////
    ifp_phase_t  phase_reg;
    ifp_phase_t  phase_next;
    logic [20:0] pc_reg;
    logic [20:0] pc_next;
    logic [20:0] fetch_addr_reg;
    logic [15:0] fetch_reg;
    logic        fetch_valid_reg;
    logic        exec_valid_reg;
    logic        flush_reg;
    logic [15:0] ir_reg;
    logic [7:0]  operand_reg;
    logic [11:0] daddr_reg;
    logic        drd_reg;
    logic        dwr_reg;
    logic [7:0]  dwr_data_reg;

    // RULE1: phase sequencing
    always_comb
    begin
        case (phase_reg)
            IFP_PHASE_ONE:   phase_next = IFP_PHASE_TWO;
            IFP_PHASE_TWO:   phase_next = IFP_PHASE_THREE;
            IFP_PHASE_THREE: phase_next = IFP_PHASE_FOUR;
            IFP_PHASE_FOUR:  phase_next = IFP_PHASE_ONE;
            default:         phase_next = IFP_PHASE_ONE;
        endcase
    end

    wire p1 = (phase_reg == IFP_PHASE_ONE);
    wire p2 = (phase_reg == IFP_PHASE_TWO);
    wire p3 = (phase_reg == IFP_PHASE_THREE);
    wire p4 = (phase_reg == IFP_PHASE_FOUR);

    ////////////////////////////////////////////////////////////////////////
    // execute qualifiers, decoder request valid only when executing
    wire        executing = exec_valid_reg & ~flush_reg;
    wire        do_jump   = executing & exec_req.absolute_jump_instr;
    wire        do_branch = executing & exec_req.relative_branch;
    wire        pc_change = do_jump | do_branch;

    // RULE10: word address into pc bits 20:1
    wire [20:0] jump_target = {exec_req.jump_word_addr, 1'b0};
    // RULE11: offset counted in words, doubled
    wire [20:0] branch_disp = {{9{exec_req.branch_offset[10]}},
                               exec_req.branch_offset, 1'b0};
    wire [20:0] branch_target = pc_reg + branch_disp;

    // RULE4: increment in phase_one; RULE9: step of two
    wire [20:0] pc_inc = pc_reg + PC_STEP;

    always_comb
    begin
        pc_next = pc_reg;
        if (p1)
            pc_next = pc_inc;
        else if (p4 && do_jump)
            pc_next = jump_target;
        else if (p4 && do_branch)
            pc_next = branch_target;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            phase_reg <= IFP_PHASE_ONE;
        else
            phase_reg <= phase_next;
    end

    // RULE9: lsb forced to zero
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            pc_reg <= PC_RESET;
        else
            pc_reg <= {pc_next[20:1], 1'b0};
    end

    // RULE12: fetch address taken before the increment
    // first cycle after reset fetches the reset address, jump targets are not skipped
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            fetch_addr_reg <= PC_RESET;
        else if (p1)
            fetch_addr_reg <= pc_reg;
    end

    // RULE8: word fetched from even address, captured at end of cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            fetch_reg <= IR_RESET;
        else if (p4)
            fetch_reg <= prog_word;
    end

    // RULE12: pipeline empty after reset
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            fetch_valid_reg <= 1'b0;
        else if (p4)
            fetch_valid_reg <= 1'b1;
    end

    // RULE3: flush prefetched word on program change
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            flush_reg <= 1'b0;
        else if (p4)
            flush_reg <= pc_change | (executing & exec_req.two_word);
        else if (p1)
            flush_reg <= flush_reg;
    end

    // RULE5: latch into instruction_register in phase_one
    // RULE2: executes the word fetched in the previous cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ir_reg         <= IR_RESET;
            exec_valid_reg <= 1'b0;
        end
        else if (p1)
        begin
            ir_reg         <= fetch_reg;
            exec_valid_reg <= fetch_valid_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RULE6: operand read in phase_two
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            daddr_reg   <= DADDR_RESET;
            drd_reg     <= 1'b0;
            operand_reg <= DATA_RESET;
        end
        else
        begin
            drd_reg <= p1 & fetch_valid_reg & ~flush_reg & exec_req.operand_read;
            if (p1)
                daddr_reg <= exec_req.data_addr;
            if (drd_reg)
                operand_reg <= data_rd;
        end
    end

    // RULE6: destination write in phase_four
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dwr_reg      <= 1'b0;
            dwr_data_reg <= DATA_RESET;
        end
        else
        begin
            dwr_reg <= p3 & executing & exec_req.dest_write;
            if (p3)
                dwr_data_reg <= result;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RULE7: byte address to program memory
    assign prog_addr            = fetch_addr_reg;
    assign prog_rd_en           = p4;
    assign instruction_register = ir_reg;
    assign instr_valid          = executing & ~p1;
    assign phase_one            = p1;
    assign phase_two            = p2;
    assign phase_three          = p3;
    assign phase_four           = p4;
    assign data_addr            = daddr_reg;
    assign data_rd_en           = drd_reg;
    assign data_wr_en           = dwr_reg;
    assign data_wr              = dwr_data_reg;
    assign operand              = operand_reg;

endmodule

// >>> tb/ifp_core_monitor.sv
module ifp_core_mon
    import ifp_pkg::*;
(
    input logic        mclk, rst_b, instr_valid, data_rd_en, data_wr_en,
    input logic        phase_one, phase_two, phase_three, phase_four,
    input ifp_exec_t   exec_req,
    input logic [20:0] prog_addr,
    input logic [15:0] instruction_register,
    input logic [7:0]  data_rd, operand
);
    default clocking mon_cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    wire        chg  = phase_four && instr_valid;
    wire [20:0] disp = {{9{exec_req.branch_offset[10]}}, exec_req.branch_offset, 1'b0};
    phase_seq_a: assert property (
        phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
        else $error("bad phase order");
    pc_align_a: assert property (prog_addr[0] == 1'b0)
        else $error("pc odd");
    pc_step_a: assert property (phase_one && $past(rst_b, 4) &&
        !$past(chg && (exec_req.absolute_jump_instr || exec_req.relative_branch))
        |=> prog_addr == $past(prog_addr) + PC_STEP)
        else $error("pc step wrong");
    ir_hold_a: assert property (!phase_one |=> $stable(instruction_register))
        else $error("ir moved");
    jump_load_a: assert property (
        chg && exec_req.absolute_jump_instr |=> ##1
        prog_addr == {$past(exec_req.jump_word_addr, 2), 1'b0})
        else $error("jump target wrong");
    branch_tgt_a: assert property (
        chg && exec_req.relative_branch && !exec_req.absolute_jump_instr |=> ##1
        prog_addr == $past(prog_addr, 2) + PC_STEP + $past(disp, 2))
        else $error("branch target wrong");
    flush_word_a: assert property (
        chg && (exec_req.absolute_jump_instr || exec_req.relative_branch || exec_req.two_word)
        |=> !instr_valid [*4])
        else $error("no flush");
    rd_phase_a: assert property (
        data_rd_en |-> phase_two && instr_valid && exec_req.operand_read)
        else $error("bad read");
    wr_phase_a: assert property (
        data_wr_en |-> phase_four && instr_valid && exec_req.dest_write)
        else $error("bad write");
    operand_cap_a: assert property (data_rd_en |=> operand == $past(data_rd))
        else $error("operand wrong");
endmodule

bind ifp_core ifp_core_mon u_mon (.*);

// >>> tb/ifp_mem_model.sv
module ifp_mem_model
(
    input  logic        prog_rd_en,
    input  logic        data_rd_en,
    input  logic [20:0] prog_addr,
    input  logic [11:0] data_addr,
    output logic [15:0] prog_word,
    output logic [7:0]  data_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [15:0] fetched = {(prog_addr[7:0] | 8'h01) ^ 8'ha5, (prog_addr[7:0] & 8'hfe) ^ 8'ha5};
    wire [7:0]  rd_val  = data_addr[7:0] ^ 8'h3c;
    // idle buses show the inverse, never a stale value
    assign prog_word = prog_rd_en ? fetched : ~fetched;
    assign data_rd   = data_rd_en ? rd_val : ~rd_val;
endmodule

// >>> tb/tb_top.sv
module tb_top
    import ifp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [20:0] pc; logic [15:0] ir; logic [11:0] da; logic v, rd;} ifp_note_t;
    logic        mclk = 1'b0, rst_b = 1'b0, valid, flush = 1'b0;
    logic        prog_rd_en, instr_valid, phase_one, phase_two, phase_three, phase_four;
    logic        data_rd_en, data_wr_en;
    ifp_exec_t   exec_req = '0;
    logic [7:0]  result = 8'h00, data_rd, data_wr, operand;
    logic [15:0] prog_word, instruction_register, seed = 16'h703e;
    logic [20:0] prog_addr, pc = PC_RESET, prev = PC_RESET;
    logic [11:0] data_addr;
    int          errors = 0, samples_checked = 0, cyc = 0;
    ifp_note_t   notes[$];
    ifp_note_t   m;
    always #50 mclk = ~mclk;
    ifp_core DUT (.*);
    ifp_mem_model u_mem (.*);
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check_val(logic [20:0] got, logic [20:0] exp, string what);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic conclude();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (4) @(negedge mclk);
        rst_b = 1'b1;
        for (int k = 0; k < 80; k++)
        begin
            valid = k >= 1 && !flush;
            seed = lfsr(seed);
            exec_req.absolute_jump_instr = seed[1:0] == 2'h1;
            exec_req.relative_branch = seed[1:0] == 2'h2;
            exec_req.two_word = seed[1:0] == 2'h3;
            exec_req.operand_read = seed[2];
            exec_req.dest_write = seed[3];
            exec_req.data_addr = seed[15:4];
            result = seed[11:4];
            seed = lfsr(seed);
            exec_req.jump_word_addr = {seed[3:0], seed};
            exec_req.branch_offset = seed[10:0];
            m.ir = {(prev[7:0] | 8'h01) ^ 8'ha5, (prev[7:0] & 8'hfe) ^ 8'ha5};
            notes.push_back('{pc, m.ir, exec_req.data_addr, valid,
                valid && exec_req.operand_read});
            prev = pc;
            if (valid && exec_req.absolute_jump_instr)
                pc = {exec_req.jump_word_addr, 1'b0};
            else if (valid && exec_req.relative_branch)
                pc = prev + PC_STEP + {{9{exec_req.branch_offset[10]}},
                    exec_req.branch_offset, 1'b0};
            else
                pc = prev + PC_STEP;
            flush = valid && (exec_req.absolute_jump_instr || exec_req.relative_branch
                || exec_req.two_word);
            repeat (4) @(negedge mclk);
        end
        conclude();
    end
    always @(negedge mclk)
        if (rst_b && phase_two === 1'b1)
        begin
            m = notes.pop_front();
            check_val(prog_addr, m.pc, "pc");
            check_val(21'(instr_valid), 21'(m.v), "valid");
            check_val(21'(data_rd_en), 21'(m.rd), "read enable");
            if (m.v)
            begin
                check_val(21'(instruction_register), 21'(m.ir), "ir");
                check_val(21'(data_addr), 21'(m.da), "data addr");
            end
        end
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 1000)
        begin
            errors++;
            conclude();
        end
    end
endmodule
